// [rtl/aspf_defs.svh]
// Register offsets, field positions and reset values of the pin function block.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit address port.
//
// Overview of operation
// - Transmitted characters leave on the serial output pin least significant bit first.
// - Received characters arrive least significant bit first and are assembled in that order.
// - Ring pin is an active-low readable input or the serial bit clock source.
// - Generator B on its pin gives an expiry pulse as timer, clock as generator.
// - Terminal-ready function makes that pin an active-low CPU-set output.
// - Set-ready pin: active-low input, generator A output, or CPU-set output zero.
// - Request-to-send is a CPU-set output; in auto mode it goes low while data waits or is sent.
// - During reset request-to-send is an input sampled as clock mode; board drives it.
// - Clear-to-send is active low; gates transmitter in auto mode, else a plain input.
// - Carrier pin: active-low input, system clock divided by two, or CPU-set output one.
// - After reset every multifunction pin takes its default modem or clock function.
// - Six inner blocks raise block interrupts; the bus interface raises none.
// - Receiver, timing unit and modem module also report second-level status sources.
// - Each FIFO has its own threshold and interrupts when it reaches that level.
// - System clock comes from the crystal oscillator or an external clock.
// - Two independent baud generators, each a clock generator or a timer.
// - Bus interface arbitrates register access and drives the interrupt request out.
// - Oscillator pin use latched only in reset; output two only with external clock.
`ifndef ASPF_DEFS_SVH
`define ASPF_DEFS_SVH

`define ASPF_OFF_PINSEL    8'h00
`define ASPF_OFF_MODOUT    8'h04
`define ASPF_OFF_PINSTAT   8'h08
`define ASPF_OFF_GEN_A     8'h0c
`define ASPF_OFF_GEN_B     8'h10
`define ASPF_OFF_SERCFG    8'h14
`define ASPF_OFF_TXDATA    8'h18
`define ASPF_OFF_RXDATA    8'h1c
`define ASPF_OFF_INTSTAT   8'h20
`define ASPF_OFF_INTEN     8'h24

`define ASPF_MOD_DTR       0
`define ASPF_MOD_RTS       1
`define ASPF_MOD_GP0       2
`define ASPF_MOD_GP1       3
`define ASPF_MOD_GP2       4
`define ASPF_MOD_AUTO      5

`define ASPF_GEN_TIMER     16
`define ASPF_GEN_EN        17

`define ASPF_SUB_FRAME     0
`define ASPF_SUB_OVERRUN   1
`define ASPF_SUB_TMR_A     2
`define ASPF_SUB_TMR_B     3
`define ASPF_SUB_MODEM     4
`define ASPF_SUB_SHIFT     8

`define ASPF_RST_PINSEL    6'h00
`define ASPF_RST_MODOUT    6'h1f
`define ASPF_RST_GEN       18'h00000
`define ASPF_RST_SERCFG    12'h000
`define ASPF_RST_INTEN     6'h00

`define ASPF_CHAR_BITS     8
`define ASPF_FRAME_BITS    10

`endif

// [rtl/aspf_pkg.sv]
// Types used by the pin function block; its baud generators use none of them.
// Assumes nothing of its surroundings.
package aspf_pkg;

	typedef enum logic [1:0] {
		ASPF_DSR_SET_READY = 2'b00,
		ASPF_DSR_GEN_A     = 2'b01,
		ASPF_DSR_GP_ZERO   = 2'b10
	} aspf_dsr_fn_t;

	typedef enum logic [1:0] {
		ASPF_CAR_INPUT     = 2'b00,
		ASPF_CAR_SYS_CLOCK = 2'b01,
		ASPF_CAR_GP_ONE    = 2'b10
	} aspf_car_fn_t;

	typedef enum logic [1:0] {
		ASPF_SRC_GEN_A = 2'b00,
		ASPF_SRC_GEN_B = 2'b01,
		ASPF_SRC_EXT   = 2'b10
	} aspf_clk_src_t;

	typedef enum logic [1:0] {
		ASPF_RX_IDLE = 2'b00,
		ASPF_RX_DATA = 2'b01,
		ASPF_RX_STOP = 2'b10
	} aspf_rx_state_t;

endpackage : aspf_pkg

// [rtl/aspf_baud_gen.sv]
// One baud rate generator that runs as a clock generator or as a timer.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module aspf_baud_gen (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	// Configuration
	input  wire logic        enable_i,
	input  wire logic        timer_mode_i,
	input  wire logic [15:0] divisor_i,
	// Results
	output logic             tick_o,
	output logic             expired_o,
	output logic             pin_o
);
	logic [15:0] cnt_reg;
	logic        tick_reg;
	logic        expired_reg;
	logic        pin_reg;

	// Divisor zero behaves as one, so the generator never stalls
	wire         hit      = enable_i & (cnt_reg == 16'h0000);
	wire  [15:0] reload   = (divisor_i == 16'h0000) ? 16'h0000 : divisor_i - 16'h0001;
	wire  [15:0] cnt_next = hit ? reload : (enable_i ? cnt_reg - 16'h0001 : reload);

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			cnt_reg     <= 16'h0000;
			tick_reg    <= 1'b0;
			expired_reg <= 1'b0;
			pin_reg     <= 1'b0;
		end else begin
			cnt_reg     <= cnt_next;
			tick_reg    <= hit;
			expired_reg <= hit & timer_mode_i;
			pin_reg     <= timer_mode_i ? hit : (pin_reg ^ hit);
		end
	end

	assign tick_o    = tick_reg;
	assign expired_o = expired_reg;
	assign pin_o     = pin_reg;

endmodule : aspf_baud_gen

// [rtl/aspf_pin_mux.sv]
// Multifunction serial and modem pins, serial shifters, FIFOs and status logic.
// Assumes pins synchronous to core_clk_i (40 MHz), an APB master, synchronous reset.
`timescale 1ns/1ps
`include "aspf_defs.svh"
module aspf_pin_mux import aspf_pkg::*; #(
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Serial data
	output logic             txd_pin_o,
	input  wire logic        rxd_pin_i,
	// Modem and timing pins
	input  wire logic        ring_sclk_pin_i,
	output logic             dtr_genb_pin_o,
	input  wire logic        dsr_gena_pin_i,
	output logic             dsr_gena_pin_o,
	output logic             dsr_gena_oe_o,
	input  wire logic        rts_pin_i,
	output logic             rts_pin_o,
	output logic             rts_oe_o,
	input  wire logic        cts_n_i,
	input  wire logic        carrier_pin_i,
	output logic             carrier_pin_o,
	output logic             carrier_oe_o,
	output logic             gp_out_two_o,
	output logic             gp_out_two_oe_o,
	// Interrupt request
	output logic             irq_o
);
	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int LW = PW + 1;

	// Picks one bit-clock tick; used for transmit and receive alike
	function automatic logic pick_tick(input logic [1:0] src, input logic a,
	                                   input logic b, input logic ext);
		pick_tick = (src == ASPF_SRC_GEN_A) ? a : (src == ASPF_SRC_GEN_B) ? b :
		            (src == ASPF_SRC_EXT) ? ext : 1'b0;
	endfunction : pick_tick

	// Registers
	logic [5:0]    pinsel_reg;
	logic [5:0]    modout_reg;
	logic [17:0]   gena_reg;
	logic [17:0]   genb_reg;
	logic [11:0]   sercfg_reg;
	logic [5:0]    inten_reg;
	logic [4:0]    sub_reg;
	logic          clk_mode_reg;
	logic          pready_reg;
	logic          pslverr_reg;
	logic [31:0]   prdata_reg;
	logic          irq_reg;
	logic          sysclk_div_reg;
	logic          ring_prev_reg;
	logic [3:0]    mdm_prev_reg;
	// Pin output flops
	logic          txd_reg;
	logic          dtr_reg;
	logic          dsr_o_reg;
	logic          dsr_oe_reg;
	logic          rts_o_reg;
	logic          rts_oe_reg;
	logic          car_o_reg;
	logic          car_oe_reg;
	logic          gp2_o_reg;
	logic          gp2_oe_reg;
	// FIFOs
	logic [7:0]    tx_mem [FIFO_DEPTH];
	logic [7:0]    rx_mem [FIFO_DEPTH];
	logic [PW-1:0] tx_wp_reg;
	logic [PW-1:0] tx_rp_reg;
	logic [LW-1:0] tx_lvl_reg;
	logic [PW-1:0] rx_wp_reg;
	logic [PW-1:0] rx_rp_reg;
	logic [LW-1:0] rx_lvl_reg;
	// Shifters
	logic [9:0]    tx_sh_reg;
	logic [3:0]    tx_cnt_reg;
	logic          tx_busy_reg;
	logic [7:0]    rx_sh_reg;
	logic [3:0]    rx_cnt_reg;
	aspf_rx_state_t rx_st_reg;
	aspf_rx_state_t rx_st_next;

	// Baud generators
	logic ga_tick, ga_exp, ga_pin, gb_tick, gb_exp, gb_pin;

	aspf_baud_gen u_gen_a (
		.core_clk_i   (core_clk_i),
		.rst_b_i      (rst_b_i),
		.enable_i     (gena_reg[`ASPF_GEN_EN]),
		.timer_mode_i (gena_reg[`ASPF_GEN_TIMER]),
		.divisor_i    (gena_reg[15:0]),
		.tick_o       (ga_tick),
		.expired_o    (ga_exp),
		.pin_o        (ga_pin)
	);

	aspf_baud_gen u_gen_b (
		.core_clk_i   (core_clk_i),
		.rst_b_i      (rst_b_i),
		.enable_i     (genb_reg[`ASPF_GEN_EN]),
		.timer_mode_i (genb_reg[`ASPF_GEN_TIMER]),
		.divisor_i    (genb_reg[15:0]),
		.tick_o       (gb_tick),
		.expired_o    (gb_exp),
		.pin_o        (gb_pin)
	);

	// Pin function fields
	wire [1:0] dsr_fn   = pinsel_reg[1:0];
	wire [1:0] car_fn   = pinsel_reg[3:2];
	wire       dtr_fn   = pinsel_reg[4];
	wire       ring_fn  = pinsel_reg[5];
	wire       auto_tx  = modout_reg[`ASPF_MOD_AUTO];
	wire [1:0] tx_src   = sercfg_reg[1:0];
	wire [1:0] rx_src   = sercfg_reg[3:2];
	wire [LW-1:0] tx_thr = LW'(sercfg_reg[6:4]);
	wire [LW-1:0] rx_thr = LW'(sercfg_reg[10:8]);

	// Bus decode
	wire apb_wait = psel_i & penable_i & ~pready_reg;
	wire apb_done = psel_i & penable_i & pready_reg;
	wire apb_wr   = apb_done & pwrite_i;
	wire apb_rd   = apb_done & ~pwrite_i;
	wire hit_pinsel  = paddr_i == `ASPF_OFF_PINSEL;
	wire hit_modout  = paddr_i == `ASPF_OFF_MODOUT;
	wire hit_pinstat = paddr_i == `ASPF_OFF_PINSTAT;
	wire hit_gena    = paddr_i == `ASPF_OFF_GEN_A;
	wire hit_genb    = paddr_i == `ASPF_OFF_GEN_B;
	wire hit_sercfg  = paddr_i == `ASPF_OFF_SERCFG;
	wire hit_txdata  = paddr_i == `ASPF_OFF_TXDATA;
	wire hit_rxdata  = paddr_i == `ASPF_OFF_RXDATA;
	wire hit_intstat = paddr_i == `ASPF_OFF_INTSTAT;
	wire hit_inten   = paddr_i == `ASPF_OFF_INTEN;
	wire hit_any = hit_pinsel | hit_modout | hit_pinstat | hit_gena | hit_genb |
	               hit_sercfg | hit_txdata | hit_rxdata | hit_intstat | hit_inten;

	// FIFO status
	wire tx_full  = tx_lvl_reg == LW'(FIFO_DEPTH);
	wire tx_empty = tx_lvl_reg == '0;
	wire rx_full  = rx_lvl_reg == LW'(FIFO_DEPTH);
	wire rx_empty = rx_lvl_reg == '0;

	// Bit clock selection; external clock only when the ring pin is so assigned
	wire sclk_tick = ring_fn & ring_sclk_pin_i & ~ring_prev_reg;
	wire tx_tick   = pick_tick(tx_src, ga_tick, gb_tick, sclk_tick);
	wire rx_tick   = pick_tick(rx_src, ga_tick, gb_tick, sclk_tick);

	// Transmitter held off by a high clear-to-send in auto mode
	wire cts_ok  = ~auto_tx | ~cts_n_i;
	wire tx_load = tx_tick & ~tx_busy_reg & ~tx_empty & cts_ok;
	wire tx_push = apb_wr & hit_txdata & ~tx_full;
	wire tx_last = tx_tick & tx_busy_reg & (tx_cnt_reg == 4'(`ASPF_FRAME_BITS - 1));

	// Receiver
	wire rx_stop_tick = rx_tick & (rx_st_reg == ASPF_RX_STOP);
	wire rx_push  = rx_stop_tick & rxd_pin_i & ~rx_full;
	wire rx_ovr   = rx_stop_tick & rxd_pin_i & rx_full;
	wire rx_ferr  = rx_stop_tick & ~rxd_pin_i;
	wire rx_pop   = apb_rd & hit_rxdata & ~rx_empty;

	always_comb begin
		rx_st_next = rx_st_reg;
		case (rx_st_reg)
			ASPF_RX_IDLE: if (rx_tick && !rxd_pin_i) rx_st_next = ASPF_RX_DATA;
			ASPF_RX_DATA: if (rx_tick && rx_cnt_reg == 4'(`ASPF_CHAR_BITS - 1))
				rx_st_next = ASPF_RX_STOP;
			ASPF_RX_STOP: if (rx_tick) rx_st_next = ASPF_RX_IDLE;
			default:      rx_st_next = ASPF_RX_IDLE;
		endcase
	end

	// Modem inputs watched only while their pin is an input
	wire [3:0] mdm_in   = {cts_n_i, carrier_pin_i, dsr_gena_pin_i, ring_sclk_pin_i};
	wire [3:0] mdm_mask = {1'b1, car_fn == ASPF_CAR_INPUT, dsr_fn == ASPF_DSR_SET_READY,
	                       ~ring_fn};
	wire       mdm_chg  = |((mdm_in ^ mdm_prev_reg) & mdm_mask);

	// Second-level sources; a new event wins over a clear in the same cycle
	wire [4:0] sub_set = {mdm_chg, gb_exp, ga_exp, rx_ovr, rx_ferr};
	wire [4:0] sub_clr = (apb_wr & hit_intstat) ? pwdata_i[`ASPF_SUB_SHIFT +: 5] : 5'h00;
	wire [4:0] sub_next = (sub_reg & ~sub_clr) | sub_set;

	// Block-level status; the bus interface itself has no entry
	wire [5:0] blk_stat = {
		sub_reg[`ASPF_SUB_TMR_B] | sub_reg[`ASPF_SUB_TMR_A],
		~tx_busy_reg & tx_empty,
		sub_reg[`ASPF_SUB_MODEM],
		sub_reg[`ASPF_SUB_OVERRUN] | sub_reg[`ASPF_SUB_FRAME],
		tx_lvl_reg <= tx_thr,
		rx_lvl_reg >= rx_thr
	};

	// Read data
	wire [31:0] pinstat_word = {25'h0000000, rx_st_reg != ASPF_RX_IDLE, tx_busy_reg,
	                            clk_mode_reg, cts_n_i, carrier_pin_i, dsr_gena_pin_i,
	                            ring_sclk_pin_i};
	wire [31:0] rd_word =
		hit_pinsel  ? {26'h0000000, pinsel_reg} :
		hit_modout  ? {26'h0000000, modout_reg} :
		hit_pinstat ? pinstat_word :
		hit_gena    ? {14'h0000, gena_reg} :
		hit_genb    ? {14'h0000, genb_reg} :
		hit_sercfg  ? {20'h00000, sercfg_reg} :
		hit_txdata  ? {{(32-LW){1'b0}}, tx_lvl_reg} :
		hit_rxdata  ? {24'h000000, rx_mem[rx_rp_reg]} :
		hit_intstat ? {19'h00000, sub_reg, 2'b00, blk_stat} :
		hit_inten   ? {26'h0000000, inten_reg} : 32'h00000000;

	// Bus interface: one wait state, then the answer
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= apb_wait;
			pslverr_reg <= apb_wait & ~hit_any;
			prdata_reg  <= (apb_wait & ~pwrite_i) ? rd_word : 32'h00000000;
		end
	end

	// Configuration; pin functions change only here
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pinsel_reg <= `ASPF_RST_PINSEL;
			modout_reg <= `ASPF_RST_MODOUT;
			gena_reg   <= `ASPF_RST_GEN;
			genb_reg   <= `ASPF_RST_GEN;
			sercfg_reg <= `ASPF_RST_SERCFG;
			inten_reg  <= `ASPF_RST_INTEN;
		end else if (apb_wr) begin
			if (hit_pinsel) pinsel_reg <= pwdata_i[5:0];
			if (hit_modout) modout_reg <= pwdata_i[5:0];
			if (hit_gena)   gena_reg   <= pwdata_i[17:0];
			if (hit_genb)   genb_reg   <= pwdata_i[17:0];
			if (hit_sercfg) sercfg_reg <= pwdata_i[11:0];
			if (hit_inten)  inten_reg  <= pwdata_i[5:0];
		end
	end

	// Clock-mode strap is taken from the request-to-send pin only while in reset
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) clk_mode_reg <= rts_pin_i;
	end

	// Status, interrupt and edge history
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			sub_reg        <= 5'h00;
			irq_reg        <= 1'b0;
			sysclk_div_reg <= 1'b0;
			ring_prev_reg  <= 1'b1;
			mdm_prev_reg   <= 4'hf;
		end else begin
			sub_reg        <= sub_next;
			irq_reg        <= |(blk_stat & inten_reg);
			sysclk_div_reg <= ~sysclk_div_reg;
			ring_prev_reg  <= ring_sclk_pin_i;
			mdm_prev_reg   <= mdm_in;
		end
	end

	// Transmit FIFO and shifter; ring buffer pointers assume a power-of-two depth
	always_ff @(posedge core_clk_i) begin
		if (tx_push) tx_mem[tx_wp_reg] <= pwdata_i[7:0];
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			tx_wp_reg   <= '0;
			tx_rp_reg   <= '0;
			tx_lvl_reg  <= '0;
			tx_sh_reg   <= 10'h3ff;
			tx_cnt_reg  <= 4'h0;
			tx_busy_reg <= 1'b0;
			txd_reg     <= 1'b1;
		end else begin
			if (tx_push) tx_wp_reg <= tx_wp_reg + 1'b1;
			if (tx_load) tx_rp_reg <= tx_rp_reg + 1'b1;
			tx_lvl_reg <= tx_lvl_reg + LW'(tx_push) - LW'(tx_load);
			if (tx_load) begin
				tx_sh_reg   <= {1'b1, tx_mem[tx_rp_reg], 1'b0};
				txd_reg     <= 1'b0;
				tx_cnt_reg  <= 4'h0;
				tx_busy_reg <= 1'b1;
			end else if (tx_tick && tx_busy_reg) begin
				tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
				txd_reg    <= tx_last ? 1'b1 : tx_sh_reg[1];
				tx_cnt_reg <= tx_cnt_reg + 4'h1;
				if (tx_last) tx_busy_reg <= 1'b0;
			end
		end
	end

	// Receive FIFO and shifter
	always_ff @(posedge core_clk_i) begin
		if (rx_push) rx_mem[rx_wp_reg] <= rx_sh_reg;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			rx_wp_reg  <= '0;
			rx_rp_reg  <= '0;
			rx_lvl_reg <= '0;
			rx_sh_reg  <= 8'h00;
			rx_cnt_reg <= 4'h0;
			rx_st_reg  <= ASPF_RX_IDLE;
		end else begin
			rx_st_reg <= rx_st_next;
			if (rx_push) rx_wp_reg <= rx_wp_reg + 1'b1;
			if (rx_pop)  rx_rp_reg <= rx_rp_reg + 1'b1;
			rx_lvl_reg <= rx_lvl_reg + LW'(rx_push) - LW'(rx_pop);
			if (rx_tick && rx_st_reg == ASPF_RX_IDLE) rx_cnt_reg <= 4'h0;
			if (rx_tick && rx_st_reg == ASPF_RX_DATA) begin
				rx_sh_reg  <= {rxd_pin_i, rx_sh_reg[7:1]};
				rx_cnt_reg <= rx_cnt_reg + 4'h1;
			end
		end
	end

	// Pin drivers; drivers released while reset holds and for input functions
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			dtr_reg    <= 1'b1;
			dsr_o_reg  <= 1'b1;
			dsr_oe_reg <= 1'b0;
			rts_o_reg  <= 1'b1;
			rts_oe_reg <= 1'b0;
			car_o_reg  <= 1'b1;
			car_oe_reg <= 1'b0;
			gp2_o_reg  <= 1'b1;
			gp2_oe_reg <= 1'b0;
		end else begin
			dtr_reg    <= dtr_fn ? gb_pin : modout_reg[`ASPF_MOD_DTR];
			dsr_o_reg  <= (dsr_fn == ASPF_DSR_GEN_A) ? ga_pin : modout_reg[`ASPF_MOD_GP0];
			dsr_oe_reg <= dsr_fn != ASPF_DSR_SET_READY;
			rts_o_reg  <= auto_tx ? ~(tx_busy_reg | ~tx_empty) : modout_reg[`ASPF_MOD_RTS];
			rts_oe_reg <= 1'b1;
			car_o_reg  <= (car_fn == ASPF_CAR_SYS_CLOCK) ? sysclk_div_reg :
			              modout_reg[`ASPF_MOD_GP1];
			car_oe_reg <= car_fn != ASPF_CAR_INPUT;
			gp2_o_reg  <= modout_reg[`ASPF_MOD_GP2];
			gp2_oe_reg <= clk_mode_reg;
		end
	end

	assign prdata_o        = prdata_reg;
	assign pready_o        = pready_reg;
	assign pslverr_o       = pslverr_reg;
	assign txd_pin_o       = txd_reg;
	assign dtr_genb_pin_o  = dtr_reg;
	assign dsr_gena_pin_o  = dsr_o_reg;
	assign dsr_gena_oe_o   = dsr_oe_reg;
	assign rts_pin_o       = rts_o_reg;
	assign rts_oe_o        = rts_oe_reg;
	assign carrier_pin_o   = car_o_reg;
	assign carrier_oe_o    = car_oe_reg;
	assign gp_out_two_o    = gp2_o_reg;
	assign gp_out_two_oe_o = gp2_oe_reg;
	assign irq_o           = irq_reg;

	// Checks
	sequence s_apb_setup;
		psel_i && !penable_i;
	endsequence

	sequence s_apb_access;
		psel_i && penable_i && !pready_reg;
	endsequence

	chk_tx_lsb_first: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		tx_load |=> !txd_pin_o && tx_sh_reg[1] == $past(tx_mem[tx_rp_reg][0]))
		else $error("first data bit is not the character lsb");

	chk_rx_lsb_first: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(rx_tick && rx_st_reg == ASPF_RX_DATA && rx_cnt_reg == 4'h7)
		|=> rx_sh_reg[7] == $past(rxd_pin_i) && rx_st_reg == ASPF_RX_STOP)
		else $error("last received bit not placed as msb");

	chk_strap_reset: assert property (@(posedge core_clk_i)
		!rst_b_i |=> !rts_oe_o && clk_mode_reg == $past(rts_pin_i))
		else $error("clock mode strap not sampled in reset");

	chk_cts_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(auto_tx && cts_n_i) |-> !tx_load)
		else $error("transmit started while clear-to-send high");

	chk_pin_release: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(dsr_fn == ASPF_DSR_SET_READY && car_fn == ASPF_CAR_INPUT)
		|=> !dsr_gena_oe_o && !carrier_oe_o)
		else $error("driver enabled on input pin");

	chk_reset_default: assert property (@(posedge core_clk_i)
		$rose(rst_b_i) |-> pinsel_reg == `ASPF_RST_PINSEL && !dsr_gena_oe_o)
		else $error("pin functions not at default after reset");

	chk_apb_answer: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		s_apb_setup ##1 s_apb_access |=> pready_o && (pslverr_o == !$past(hit_any)))
		else $error("register access not answered after one wait state");

	chk_fifo_thresh: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(rx_lvl_reg >= rx_thr && inten_reg[0]) |=> irq_o)
		else $error("receive threshold did not raise interrupt");

	chk_genb_pin: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		$past(dtr_fn) && dtr_fn |-> dtr_genb_pin_o == $past(gb_pin))
		else $error("generator B not routed to its pin");

	chk_gp2_only_ext: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!clk_mode_reg |=> !gp_out_two_oe_o ##1 !gp_out_two_oe_o)
		else $error("output two driven in crystal mode");

endmodule : aspf_pin_mux

// [test/aspf_line_model.sv]
// Serial line partner: supplies the external bit clock and receive data.
// Assumes the design takes a bit clock rising edge as one tick.
`timescale 1ns/1ps
module aspf_line_model (
	// Core clock for pacing
	input  wire logic core_clk_i,
	// Serial pins
	input  wire logic txd_i,
	output logic      sclk_o,
	output logic      rxd_o
);
	initial begin
		sclk_o = 1'b0;
		rxd_o  = 1'b1;
	end

	// Bit clock only runs inside a frame; data moves on its falling half
	task automatic frame(input logic [7:0] c, output logic [9:0] got);
		logic [10:0] bits;
		bits = {2'b11, c, 1'b0};
		for (int i = 0; i <= 10; i++) begin
			rxd_o <= bits[i];
			repeat (8) @(posedge core_clk_i);
			if (i > 0)
				got[i-1] = txd_i;
			sclk_o <= 1'b1;
			repeat (8) @(posedge core_clk_i);
			sclk_o <= 1'b0;
		end
	endtask : frame
endmodule : aspf_line_model

// [test/async_serial_pin_functions_tb.sv]
// Self-checking bench for the pin function block with an APB master.
// Assumes one APB answer per access and the line model for serial traffic.
`timescale 1ns/1ps
`include "aspf_defs.svh"
`define CMP(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module async_serial_pin_functions_tb;
	logic        core_clk_i, rst_b_i, psel, penable, pwrite, strap;
	logic        ring_drv, dsr_drv, car_drv, cts_n, sclk, rxd, txd, pready, pslverr;
	logic        dtr, dsr_o, dsr_oe, rts_o, rts_oe, car_o, car_oe, gp2, gp2_oe, irq;
	logic [7:0]  paddr, c;
	logic [9:0]  f;
	logic [31:0] pwdata, prdata, v;
	logic [64:0] note;
	logic [64:0] exp_q[$];
	int          error_cnt, cmp_count, n, tb;
	int          seed = 58095;

	aspf_pin_mux dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .txd_pin_o(txd),
		.rxd_pin_i(rxd), .ring_sclk_pin_i(sclk | ring_drv), .dtr_genb_pin_o(dtr),
		.dsr_gena_pin_i((dsr_oe === 1'b1) ? dsr_o : dsr_drv), .dsr_gena_pin_o(dsr_o),
		.dsr_gena_oe_o(dsr_oe), .rts_pin_i((rts_oe === 1'b1) ? rts_o : strap),
		.rts_pin_o(rts_o), .rts_oe_o(rts_oe), .cts_n_i(cts_n),
		.carrier_pin_i((car_oe === 1'b1) ? car_o : car_drv),
		.carrier_pin_o(car_o), .carrier_oe_o(car_oe), .gp_out_two_o(gp2),
		.gp_out_two_oe_o(gp2_oe), .irq_o(irq));
	// Undriven pins show the board level, also before the first reset edge
	aspf_line_model line (.core_clk_i(core_clk_i), .txd_i(txd), .sclk_o(sclk), .rxd_o(rxd));

	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			error_cnt++;
			conclude();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk_i);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic err = 1'b0);
		exp_q.push_back({m, err, e & m});
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Read answers are matched in order against the noted expectations
	always @(posedge core_clk_i) begin
		if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			`CMP("read", note[32:0], {pslverr, prdata & note[64:33]})
		end
	end

	task automatic do_reset(input logic s);
		rst_b_i <= 1'b0;
		strap <= s;
		repeat (16) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		#1;
		`CMP("rts_oe", 1'b1, rts_oe)
		`CMP("gp2_oe", s, gp2_oe)
		`CMP("in_oe", 3'b001, {dsr_oe, car_oe, dtr})
		@(posedge core_clk_i);
		rd(`ASPF_OFF_PINSTAT, 32'h10, {27'h0, s, 4'h0});
		rd(`ASPF_OFF_PINSEL, 32'h3f, 32'h0);
		rd(`ASPF_OFF_MODOUT, 32'h3f, 32'h1f);
		$display("reset test done");
	endtask : do_reset

	initial begin
		{psel, penable, pwrite, ring_drv, rst_b_i} = 5'b0;
		{dsr_drv, car_drv, cts_n, strap} = 4'hf;
		paddr = 8'h0;
		pwdata = 32'h0;
		do_reset(1'b1);
		apb(1'b1, `ASPF_OFF_PINSEL, 32'h0a);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			apb(1'b1, `ASPF_OFF_MODOUT, v & 32'h1f);
			// Pin flops follow the register one edge after the write
			@(posedge core_clk_i);
			`CMP("dtr_rts", v[1:0], {rts_o, dtr})
			`CMP("gp0", {1'b1, v[2]}, {dsr_oe, dsr_o})
			`CMP("gp1_gp2", {1'b1, v[4:3]}, {car_oe, gp2, car_o})
		end
		$display("output test done");
		apb(1'b1, `ASPF_OFF_PINSEL, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			{cts_n, car_drv, dsr_drv, ring_drv} <= v[3:0];
			repeat (4) @(posedge core_clk_i);
			rd(`ASPF_OFF_PINSTAT, 32'hf, v);
			`CMP("in_oe", 2'b00, {dsr_oe, car_oe})
		end
		rd(8'h28, 32'hffffffff, 32'h0, 1'b1);
		$display("input test done");
		apb(1'b1, `ASPF_OFF_GEN_B, 32'h20003);
		apb(1'b1, `ASPF_OFF_PINSEL, 32'h14);
		{n, tb} = 0;
		@(posedge core_clk_i);
		for (int i = 0; i < 24; i++) begin
			v[1:0] = {dtr, car_o};
			@(posedge core_clk_i);
			n += (car_o !== v[0]);
			tb += (dtr !== v[1]);
		end
		`CMP("sys_clk", 24, n)
		`CMP("gen_b", 1'b1, tb >= 7 && tb <= 8)
		$display("clock test done");
		apb(1'b1, `ASPF_OFF_GEN_B, 32'h0);
		ring_drv <= 1'b0;
		cts_n <= 1'b1;
		apb(1'b1, `ASPF_OFF_PINSEL, 32'h20);
		apb(1'b1, `ASPF_OFF_SERCFG, 32'h20a);
		apb(1'b1, `ASPF_OFF_INTEN, 32'h1);
		apb(1'b1, `ASPF_OFF_MODOUT, 32'h3f);
		c = $random(seed);
		apb(1'b1, `ASPF_OFF_TXDATA, {24'h0, c});
		repeat (4) @(posedge core_clk_i);
		`CMP("rts_auto", 1'b0, rts_o)
		`CMP("irq", 1'b0, irq)
		line.frame(c ^ 8'h5a, f);
		`CMP("held", 10'h3ff, f)
		cts_n <= 1'b0;
		line.frame(c, f);
		`CMP("txd", {1'b1, c, 1'b0}, f)
		`CMP("irq", 1'b1, irq)
		rd(`ASPF_OFF_RXDATA, 32'hff, {24'h0, c ^ 8'h5a});
		rd(`ASPF_OFF_RXDATA, 32'hff, {24'h0, c});
		`CMP("irq", 1'b0, irq)
		$display("serial test done");
		do_reset(1'b0);
		conclude();
	end

	initial begin
		repeat (60000) @(posedge core_clk_i);
		error_cnt++;
		conclude();
	end
endmodule : async_serial_pin_functions_tb
